//--- pkg/irq_cmd_pkg.sv
// constants and carrier types of the second interrupt-enable and upper command registers
package irq_cmd_pkg;
   // register byte offsets
   localparam logic [7:0] IEN_PRI_OFS = 8'h38;
   localparam logic [7:0] STS_SECOND_OFS = 8'h80;
   localparam logic [7:0] IEN_SEC_OFS = 8'h84;
   localparam logic [7:0] CMD_UPPER_OFS = 8'h88;
   localparam logic [7:0] IRQ_MASK_OFS = 8'hA0;
   localparam logic [7:0] PM_FIRST_OFS = 8'hC0;
   // enable, status and mask field positions
   localparam int TX_EARLY_BIT = 31;
   localparam int RX_EARLY_BIT = 30;
   localparam int XCVR_BIT = 29;
   localparam int TX_DEF_BIT = 28;
   localparam int SUM_NORM_BIT = 16;
   localparam int SUM_ABN_BIT = 15;
   localparam int SHARED_W = 15;
   // command field positions
   localparam int DEEP_SLEEP_WAKE_SUPPORT_BIT = 31;
   localparam int AUX_LSB = 28;
   localparam int LED4_BIT = 23;
   localparam int RFS_LSB = 21;
   localparam int PM_WAKE_BIT = 31;
   localparam int EE_BASE = 16;
   // reset and load values
   localparam logic [3:0] IEN_HI_RST = 4'h0;
   localparam logic [14:0] IEN_LOW_RST = 15'h0000;
   localparam logic SUM_EN_RST = 1'b0;
   localparam logic STS_NORM_RST = 1'b0;
   localparam logic STS_ABN_RST = 1'b1;
   localparam logic DEEP_SLEEP_WAKE_SUPPORT_RST = 1'b0;
   localparam logic LED4_RST = 1'b0;
   localparam logic [2:0] AUX_RST = 3'h0;
   localparam logic [2:0] AUX_WAKE = 3'h7;
   localparam logic [1:0] RFS_RST = 2'h2;
   localparam logic [1:0] RFS_1K = 2'h3;
   localparam logic [11:0] FIFO_1K_BYTES = 12'h400;
   localparam logic [11:0] FIFO_2K_BYTES = 12'h800;
   // cycles to wait for the serial prom word before keeping defaults
   localparam int EE_WAIT_CYCLES = 1024;

   typedef struct packed {
      logic tx_early;
      logic rx_early;
      logic xcvr;
      logic tx_deferred;
   } add_event_t;

   typedef struct packed {
      logic speed100;
      logic link;
      logic activity;
      logic full_duplex;
      logic collision;
   } link_status_t;
endpackage : irq_cmd_pkg

//--- verilog/ee_reload_seq.sv
// fetch of the upper command word from the serial prom after reset or on request
`timescale 1ns/1ps
`default_nettype none
module ee_reload_seq #(
   parameter int WAIT_CYCLES = irq_cmd_pkg::EE_WAIT_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // prom side
   input wire logic reload,
   input wire logic ee_valid,
   input wire logic [15:0] ee_data,
   output logic ee_req,
   // register side
   output logic load_pulse,
   output logic [15:0] load_data
);
   typedef enum logic [1:0] {ST_FETCH = 2'b01, ST_IDLE = 2'b10} ld_state_t;
   ld_state_t state_reg, state_next;
   logic [15:0] wait_reg, wait_next;
   logic load_next;
   logic [15:0] data_reg, data_next;

   generate
      if (WAIT_CYCLES < 1 || WAIT_CYCLES > 65535) begin : g_bad_wait
         $error("WAIT_CYCLES out of range");
      end
   endgenerate

   always_comb begin
      state_next = state_reg;
      wait_next = wait_reg;
      load_next = 1'b0;
      data_next = data_reg;
      case (state_reg)
         ST_FETCH: begin
            if (ee_valid) begin
               load_next = 1'b1;
               data_next = ee_data;
               state_next = ST_IDLE;
            end else if (wait_reg == 16'(WAIT_CYCLES - 1)) begin
               // no prom answer: defaults stay in place
               state_next = ST_IDLE;
            end else begin
               wait_next = wait_reg + 16'h0001;
            end
         end
         ST_IDLE: begin
            if (reload) begin
               wait_next = 16'h0000;
               state_next = ST_FETCH;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_FETCH;
         wait_reg <= 16'h0000;
         load_pulse <= 1'b0;
         data_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         wait_reg <= wait_next;
         load_pulse <= load_next;
         data_reg <= data_next;
      end
   end

   assign ee_req = (state_reg == ST_FETCH);
   assign load_data = data_reg;
endmodule : ee_reload_seq
`default_nettype wire

//--- verilog/led_drive.sv
// three- or four-lamp status display driver
`timescale 1ns/1ps
`default_nettype none
module led_drive (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // mode and link state
   input wire logic four_led_select,
   input wire irq_cmd_pkg::link_status_t link_st,
   // lamps
   output logic [3:0] led
);
   logic [3:0] led_next;

   always_comb begin
      if (four_led_select) begin
         led_next[0] = link_st.link & link_st.speed100;
         led_next[1] = link_st.link & ~link_st.speed100;
         led_next[2] = link_st.activity;
         led_next[3] = link_st.full_duplex | link_st.collision;
      end else begin
         // link lamp blinks off while traffic passes
         led_next[0] = link_st.speed100;
         led_next[1] = link_st.link & ~link_st.activity;
         led_next[2] = link_st.full_duplex | link_st.collision;
         led_next[3] = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         led <= 4'h0;
      end else begin
         led <= led_next;
      end
   end
endmodule : led_drive
`default_nettype wire

//--- verilog/irq_enable2_and_command_regs.sv
// second interrupt-enable register, upper command register and added-interrupt status
`timescale 1ns/1ps
`default_nettype none
module irq_enable2_and_command_regs #(
   parameter int EE_WAIT = irq_cmd_pkg::EE_WAIT_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // added interrupt sources
   input wire irq_cmd_pkg::add_event_t add_evt,
   // serial prom
   input wire logic ee_reload,
   input wire logic ee_valid,
   input wire logic [15:0] ee_data,
   output logic ee_req,
   // power
   input wire logic aux_power_detect,
   output logic pm_wake_d3cold,
   // summaries and interrupt
   output logic normal_summary_add,
   output logic abnormal_summary_add,
   output logic [14:0] ien_shared,
   output logic irq,
   // link lamps and fifo size
   input wire irq_cmd_pkg::link_status_t link_st,
   output logic [3:0] led,
   output logic [11:0] rx_fifo_bytes,
   output logic rx_fifo_1k
);
   ////////////////////////////////////////////////////////////////////////////
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic [31:0] wmask;
   logic req, wr, wr_pri, wr_sec, wr_cmd, wr_sts, wr_msk;
   logic [31:0] wval_pri, wval_sec, wval_cmd, wval_msk;
   logic [31:0] view_pri, view_sec, view_cmd, view_sts, view_msk, view_pm;

   logic [3:0] ien_hi_reg, ien_hi_next;
   logic added_normal_summary_enable_reg, added_normal_summary_enable_next;
   logic added_abnormal_summary_enable_reg, added_abnormal_summary_enable_next;
   logic [14:0] ien_low_reg, ien_low_next;

   logic deep_sleep_wake_support_reg, deep_sleep_wake_support_next;
   logic [2:0] aux_reg, aux_next;
   logic four_led_reg, four_led_next;
   logic [1:0] rfs_reg, rfs_next;

   logic [3:0] sts_hi_reg, sts_hi_next;
   logic ans_reg, ans_next;
   logic aas_reg, aas_next;
   logic [3:0] msk_hi_reg, msk_hi_next;
   logic mans_reg, mans_next;
   logic maas_reg, maas_next;

   logic norm_reg, norm_next, abn_reg, abn_next;
   logic pm_reg, pm_next, irq_reg, irq_next;
   logic [11:0] fifo_reg, fifo_next;
   logic [3:0] ev4, clr_hi;
   logic ee_load;
   logic [15:0] ee_word;

   ////////////////////////////////////////////////////////////////////////////
   // byte lanes
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign wmask[8*b+7:8*b] = {8{wb_sel_i[b]}};
      end
      if (EE_WAIT < 1) begin : g_bad_wait
         $error("EE_WAIT must be at least one");
      end
   endgenerate

   assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign wr = req & wb_we_i;
   assign wr_pri = wr & (wb_adr_i == irq_cmd_pkg::IEN_PRI_OFS);
   assign wr_sec = wr & (wb_adr_i == irq_cmd_pkg::IEN_SEC_OFS);
   assign wr_cmd = wr & (wb_adr_i == irq_cmd_pkg::CMD_UPPER_OFS);
   assign wr_sts = wr & (wb_adr_i == irq_cmd_pkg::STS_SECOND_OFS);
   assign wr_msk = wr & (wb_adr_i == irq_cmd_pkg::IRQ_MASK_OFS);

   ////////////////////////////////////////////////////////////////////////////
   // register views, reserved bits zero
   always_comb begin
      view_pri = 32'h00000000;
      view_pri[14:0] = ien_low_reg;
      view_sec = 32'h00000000;
      view_sec[irq_cmd_pkg::TX_EARLY_BIT:irq_cmd_pkg::TX_DEF_BIT] = ien_hi_reg;
      view_sec[irq_cmd_pkg::SUM_NORM_BIT] = added_normal_summary_enable_reg;
      view_sec[irq_cmd_pkg::SUM_ABN_BIT] = added_abnormal_summary_enable_reg;
      view_sec[14:0] = ien_low_reg;
      view_cmd = 32'h00000000;
      view_cmd[irq_cmd_pkg::DEEP_SLEEP_WAKE_SUPPORT_BIT] = deep_sleep_wake_support_reg;
      view_cmd[irq_cmd_pkg::AUX_LSB+2:irq_cmd_pkg::AUX_LSB] = aux_reg;
      view_cmd[irq_cmd_pkg::LED4_BIT] = four_led_reg;
      view_cmd[irq_cmd_pkg::RFS_LSB+1:irq_cmd_pkg::RFS_LSB] = rfs_reg;
      view_sts = 32'h00000000;
      view_sts[irq_cmd_pkg::TX_EARLY_BIT:irq_cmd_pkg::TX_DEF_BIT] = sts_hi_reg;
      view_sts[irq_cmd_pkg::SUM_NORM_BIT] = ans_reg;
      view_sts[irq_cmd_pkg::SUM_ABN_BIT] = aas_reg;
      view_msk = 32'h00000000;
      view_msk[irq_cmd_pkg::TX_EARLY_BIT:irq_cmd_pkg::TX_DEF_BIT] = msk_hi_reg;
      view_msk[irq_cmd_pkg::SUM_NORM_BIT] = mans_reg;
      view_msk[irq_cmd_pkg::SUM_ABN_BIT] = maas_reg;
      view_pm = 32'h00000000;
      view_pm[irq_cmd_pkg::PM_WAKE_BIT] = pm_reg;
   end

   assign wval_pri = (view_pri & ~wmask) | (wb_dat_i & wmask);
   assign wval_sec = (view_sec & ~wmask) | (wb_dat_i & wmask);
   assign wval_cmd = (view_cmd & ~wmask) | (wb_dat_i & wmask);
   assign wval_msk = (view_msk & ~wmask) | (wb_dat_i & wmask);

   ////////////////////////////////////////////////////////////////////////////
   // bus answer: one cycle after the request, unmapped reads give zero
   always_comb begin
      ack_next = req;
      rdat_next = rdat_reg;
      if (req) begin
         case (wb_adr_i)
            irq_cmd_pkg::IEN_PRI_OFS: rdat_next = view_pri;
            irq_cmd_pkg::IEN_SEC_OFS: rdat_next = view_sec;
            irq_cmd_pkg::CMD_UPPER_OFS: rdat_next = view_cmd;
            irq_cmd_pkg::STS_SECOND_OFS: rdat_next = view_sts;
            irq_cmd_pkg::IRQ_MASK_OFS: rdat_next = view_msk;
            irq_cmd_pkg::PM_FIRST_OFS: rdat_next = view_pm;
            default: rdat_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h00000000;
      end else begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // enable registers
   always_comb begin
      ien_hi_next = ien_hi_reg;
      added_normal_summary_enable_next = added_normal_summary_enable_reg;
      added_abnormal_summary_enable_next = added_abnormal_summary_enable_reg;
      ien_low_next = ien_low_reg;
      if (wr_pri) begin
         ien_low_next = wval_pri[14:0];
      end
      if (wr_sec) begin
         ien_hi_next = wval_sec[irq_cmd_pkg::TX_EARLY_BIT:irq_cmd_pkg::TX_DEF_BIT];
         added_normal_summary_enable_next = wval_sec[irq_cmd_pkg::SUM_NORM_BIT];
         added_abnormal_summary_enable_next = wval_sec[irq_cmd_pkg::SUM_ABN_BIT];
         ien_low_next = wval_sec[14:0];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ien_hi_reg <= irq_cmd_pkg::IEN_HI_RST;
         added_normal_summary_enable_reg <= irq_cmd_pkg::SUM_EN_RST;
         added_abnormal_summary_enable_reg <= irq_cmd_pkg::SUM_EN_RST;
         ien_low_reg <= irq_cmd_pkg::IEN_LOW_RST;
      end else begin
         ien_hi_reg <= ien_hi_next;
         added_normal_summary_enable_reg <= added_normal_summary_enable_next;
         added_abnormal_summary_enable_reg <= added_abnormal_summary_enable_next;
         ien_low_reg <= ien_low_next;
      end
   end

   assign ien_shared = ien_low_reg;

   ////////////////////////////////////////////////////////////////////////////
   // command register, prom load wins over a software write
   ee_reload_seq #(
      .WAIT_CYCLES(EE_WAIT)
   ) u_reload (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .reload(ee_reload),
      .ee_valid(ee_valid),
      .ee_data(ee_data),
      .ee_req(ee_req),
      .load_pulse(ee_load),
      .load_data(ee_word)
   );

   always_comb begin
      deep_sleep_wake_support_next = deep_sleep_wake_support_reg;
      aux_next = aux_reg;
      four_led_next = four_led_reg;
      rfs_next = rfs_reg;
      if (ee_load) begin
         // upper half taken from the prom word
         deep_sleep_wake_support_next = ee_word[irq_cmd_pkg::DEEP_SLEEP_WAKE_SUPPORT_BIT-irq_cmd_pkg::EE_BASE];
         four_led_next = ee_word[irq_cmd_pkg::LED4_BIT-irq_cmd_pkg::EE_BASE];
         rfs_next = ee_word[irq_cmd_pkg::RFS_LSB-irq_cmd_pkg::EE_BASE+:2];
         // load default follows the wake capability and aux power detect
         aux_next = (deep_sleep_wake_support_next && aux_power_detect) ? irq_cmd_pkg::AUX_WAKE : irq_cmd_pkg::AUX_RST;
      end else if (wr_cmd) begin
         deep_sleep_wake_support_next = wval_cmd[irq_cmd_pkg::DEEP_SLEEP_WAKE_SUPPORT_BIT];
         aux_next = wval_cmd[irq_cmd_pkg::AUX_LSB+:3];
         four_led_next = wval_cmd[irq_cmd_pkg::LED4_BIT];
         rfs_next = wval_cmd[irq_cmd_pkg::RFS_LSB+:2];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         deep_sleep_wake_support_reg <= irq_cmd_pkg::DEEP_SLEEP_WAKE_SUPPORT_RST;
         aux_reg <= irq_cmd_pkg::AUX_RST;
         four_led_reg <= irq_cmd_pkg::LED4_RST;
         rfs_reg <= irq_cmd_pkg::RFS_RST;
      end else begin
         deep_sleep_wake_support_reg <= deep_sleep_wake_support_next;
         aux_reg <= aux_next;
         four_led_reg <= four_led_next;
         rfs_reg <= rfs_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // added status: set wins over a write-one clear
   assign ev4 = {add_evt.tx_early, add_evt.rx_early, add_evt.xcvr, add_evt.tx_deferred};
   assign clr_hi = wr_sts ? (wb_dat_i[31:28] & wmask[31:28]) : 4'h0;

   always_comb begin
      sts_hi_next = (sts_hi_reg & ~clr_hi) | ev4;
      ans_next = (ans_reg & ~(wr_sts & wmask[16] & wb_dat_i[16])) | (|(ev4[3:2] & ien_hi_reg[3:2]));
      aas_next = (aas_reg & ~(wr_sts & wmask[15] & wb_dat_i[15])) | (|(ev4[1:0] & ien_hi_reg[1:0]));
      msk_hi_next = wr_msk ? wval_msk[31:28] : msk_hi_reg;
      mans_next = wr_msk ? wval_msk[16] : mans_reg;
      maas_next = wr_msk ? wval_msk[15] : maas_reg;
      // tx/rx early into the normal summary
      norm_next = added_normal_summary_enable_reg & (|(sts_hi_reg[3:2] & ien_hi_reg[3:2]));
      // bit 27 has no source, so only 29 and 28 feed it
      abn_next = added_abnormal_summary_enable_reg & (|(sts_hi_reg[1:0] & ien_hi_reg[1:0]));
      irq_next = (|(sts_hi_reg & msk_hi_reg)) | (ans_reg & mans_reg) | (aas_reg & maas_reg);
      pm_next = deep_sleep_wake_support_reg & aux_power_detect;
      // reserved codes fall back to the larger fifo
      fifo_next = (rfs_reg == irq_cmd_pkg::RFS_1K) ? irq_cmd_pkg::FIFO_1K_BYTES : irq_cmd_pkg::FIFO_2K_BYTES;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sts_hi_reg <= 4'h0;
         ans_reg <= irq_cmd_pkg::STS_NORM_RST;
         aas_reg <= irq_cmd_pkg::STS_ABN_RST;
         msk_hi_reg <= 4'h0;
         mans_reg <= 1'b0;
         maas_reg <= 1'b0;
         norm_reg <= 1'b0;
         abn_reg <= 1'b0;
         irq_reg <= 1'b0;
         pm_reg <= 1'b0;
         fifo_reg <= irq_cmd_pkg::FIFO_2K_BYTES;
      end else begin
         sts_hi_reg <= sts_hi_next;
         ans_reg <= ans_next;
         aas_reg <= aas_next;
         msk_hi_reg <= msk_hi_next;
         mans_reg <= mans_next;
         maas_reg <= maas_next;
         norm_reg <= norm_next;
         abn_reg <= abn_next;
         irq_reg <= irq_next;
         pm_reg <= pm_next;
         fifo_reg <= fifo_next;
      end
   end

   assign normal_summary_add = norm_reg;
   assign abnormal_summary_add = abn_reg;
   assign irq = irq_reg;
   assign pm_wake_d3cold = pm_reg;
   assign rx_fifo_bytes = fifo_reg;
   assign rx_fifo_1k = (fifo_reg == irq_cmd_pkg::FIFO_1K_BYTES);

   ////////////////////////////////////////////////////////////////////////////
   // lamp set chosen by mode bit
   led_drive u_led (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .four_led_select(four_led_reg),
      .link_st(link_st),
      .led(led)
   );

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   norm_route_a: assert property (
      add_evt.tx_early && ien_hi_reg[3] && added_normal_summary_enable_reg && !wr_sec |-> ##2 normal_summary_add)
      else $error("tx early did not reach normal summary");
   abn_route_a: assert property (
      add_evt.xcvr && ien_hi_reg[1] && added_abnormal_summary_enable_reg && !wr_sec |-> ##2 abnormal_summary_add)
      else $error("transceiver event did not reach abnormal summary");
   sum_enable_a: assert property (
      wr_sec && wb_sel_i[2] |=> added_normal_summary_enable_reg == $past(wb_dat_i[16]))
      else $error("summary enable write lost");
   shared_low_a: assert property (
      wr_pri && wb_sel_i[0] && !wr_sec |=> view_sec[7:0] == $past(wb_dat_i[7:0]))
      else $error("shared enable bits differ between views");
   ee_load_a: assert property (
      ee_load |-> ##1 (deep_sleep_wake_support_reg == $past(ee_word[15]) && rfs_reg == $past(ee_word[6:5])))
      else $error("prom word not loaded");
   pm_wake_a: assert property (
      !deep_sleep_wake_support_reg ##1 !deep_sleep_wake_support_reg |-> !pm_wake_d3cold)
      else $error("wake support shown without enable");
   aux_default_a: assert property (
      ee_load && aux_power_detect && ee_word[15] |=> aux_reg == 3'h7)
      else $error("aux current default wrong");
   three_lamp_a: assert property (
      $past(!four_led_reg) |-> led[3] == 1'b0)
      else $error("fourth lamp lit in three-lamp mode");
   act_lamp_a: assert property (
      $past(four_led_reg && link_st.activity) |-> led[2])
      else $error("activity lamp dark in four-lamp mode");
   fifo_size_a: assert property (
      rfs_reg == 2'h3 ##1 rfs_reg == 2'h3 |-> rx_fifo_bytes == 12'h400)
      else $error("fifo size code not honoured");
   ans_hold_a: assert property (
      ans_reg && !(wr_sts && wb_sel_i[2] && wb_dat_i[16]) |=> ans_reg)
      else $error("added normal status dropped without clear");
   cmd_rsvd_a: assert property (
      wb_ack_o && !wb_we_i && $past(wb_adr_i) == 8'h88 |-> wb_dat_o[27:24] == 4'h0 && !wb_dat_o[20])
      else $error("reserved command bits not zero");

   irq_seen_c: cover property (add_evt.rx_early ##[1:4] irq);
   ee_load_c: cover property (ee_load ##1 four_led_reg);
   w1c_c: cover property (ans_reg ##1 wr_sts ##1 !ans_reg);
endmodule : irq_enable2_and_command_regs
`default_nettype wire

//--- tb/prom_model.sv
// serial prom model that answers each fetch request after a short delay
`timescale 1ns/1ps
`default_nettype none
module prom_model #(
   parameter int DELAY = 3
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ee_req,
   input wire logic [15:0] word,
   output logic ee_valid,
   output logic [15:0] ee_data
);
   int cnt;
   // one word per request
   // data lines toggle outside the answer so a stale word cannot pass
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 0;
         ee_valid <= 1'b0;
         ee_data <= 16'h5A5A;
      end else begin
         ee_valid <= ee_req && cnt == DELAY;
         ee_data <= (ee_req && cnt == DELAY) ? word : ~ee_data;
         cnt <= ee_req ? ((cnt <= DELAY) ? cnt + 1 : cnt) : 0;
      end
   end
endmodule : prom_model
`default_nettype wire

//--- tb/irq_enable2_and_command_regs_tb.sv
// self-checking bench for the enable and upper command registers
`timescale 1ns/1ps
`default_nettype none
module irq_enable2_and_command_regs_tb;
   logic core_clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, ee_reload = 0, aux = 1, ee_valid, ee_req;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] dat = 32'h0, dat_o, r = 32'h95381100;
   logic [15:0] ee_data, word = 16'h80E0;
   logic ack, nsum, asum, irq, pm, f1k;
   logic [14:0] ien;
   logic [3:0] led;
   logic [11:0] fb;
   irq_cmd_pkg::add_event_t evt = '0;
   irq_cmd_pkg::link_status_t ls = '0;
   logic [31:0] exp_q[$], msk_q[$];
   int n_errors = 0, num_checks = 0, cycles = 0;
   always #4 core_clk = ~core_clk;
   irq_enable2_and_command_regs #(.EE_WAIT(8)) dut_u (.core_clk(core_clk), .arst_n(arst_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .add_evt(evt), .ee_reload(ee_reload), .ee_valid(ee_valid), .ee_data(ee_data),
      .ee_req(ee_req), .aux_power_detect(aux), .pm_wake_d3cold(pm), .normal_summary_add(nsum),
      .abnormal_summary_add(asum), .ien_shared(ien), .irq(irq), .link_st(ls), .led(led),
      .rx_fifo_bytes(fb), .rx_fifo_1k(f1k));
   prom_model prom_u (.core_clk(core_clk), .arst_n(arst_n), .ee_req(ee_req), .word(word),
      .ee_valid(ee_valid), .ee_data(ee_data));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (e !== s) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      int n;
      n = 0;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      if (!w) begin
         exp_q.push_back(d);
         msk_q.push_back(m);
      end
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk("ack", 1, 0);
         conclude();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic wait_n(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_n
   task automatic pulse(input logic [3:0] e);
      @(posedge core_clk);
      evt <= e;
      @(posedge core_clk);
      evt <= '0;
      wait_n(3);
   endtask : pulse
   task automatic leds(input logic four);
      repeat (4) begin
         r = lfsr(r);
         @(posedge core_clk);
         ls <= r[4:0];
         wait_n(3);
         if (four) chk("led", {ls.full_duplex | ls.collision, ls.activity, ls.link & ~ls.speed100,
            ls.link & ls.speed100}, led);
         else chk("led", {1'b0, ls.full_duplex | ls.collision, ls.link & ~ls.activity, ls.speed100}, led);
      end
   endtask : leds
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////
   // read data checked against the oldest note when ack shows
   always @(posedge core_clk) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         conclude();
      end
      if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
         chk("rdata", exp_q[0] & msk_q[0], dat_o & msk_q[0]);
         exp_q.delete(0);
         msk_q.delete(0);
      end
   end
   initial begin
      wait_n(2);
      arst_n <= 1'b1;
      bus(0, 8'h84, 32'h0, '1);
      bus(0, 8'hF0, 32'h0, '1);
      for (int i = 0; i < 20 && ee_req !== 1'b0; i++) wait_n(1);
      wait_n(3);
      bus(0, 8'h88, 32'hF0E0_0000, '1);
      chk("pm", 1, pm);
      chk("fifo", 32'h1400, {f1k, fb});
      leds(1);
      bus(1, 8'h88, 32'h0F30_0000, 0);
      bus(0, 8'h88, 32'h0020_0000, '1);
      wait_n(2);
      chk("pm", 0, pm);
      chk("fifo", 32'h0800, {f1k, fb});
      leds(0);
      r = lfsr(r);
      bus(1, 8'h38, {17'h0, r[14:0]}, 0);
      bus(0, 8'h84, {17'h0, r[14:0]}, '1);
      chk("ien", r[14:0], ien);
      r = lfsr(r);
      bus(1, 8'h84, 32'hF001_8000 | r[14:0], 0);
      bus(0, 8'h84, 32'hF001_8000 | r[14:0], '1);
      bus(0, 8'h38, r[14:0], 32'h0000_7FFF);
      bus(1, 8'hA0, 32'h0001_0000, 0);
      bus(1, 8'h80, 32'hFFFF_FFFF, 0);
      bus(0, 8'h80, 32'h0, '1);
      pulse(4'b1000);
      chk("sum", 2'b10, {nsum, asum});
      chk("irq", 1, irq);
      bus(0, 8'h80, 32'h8001_0000, '1);
      bus(1, 8'h80, 32'h0001_0000, 0);
      bus(0, 8'h80, 32'h8000_0000, '1);
      chk("sum", 3'b100, {nsum, asum, irq});
      pulse(4'b0010);
      chk("sum", 2'b11, {nsum, asum});
      bus(0, 8'h80, 32'hA000_8000, '1);
      bus(1, 8'h84, 32'hF000_0000, 0);
      bus(1, 8'h80, 32'hFFFF_FFFF, 0);
      pulse(4'b0100);
      chk("sum", 3'b001, {nsum, asum, irq});
      sel <= 4'h3;
      bus(1, 8'h84, 32'h0000_0000, 0);
      sel <= 4'hF;
      bus(0, 8'h84, 32'hF000_0000, '1);
      word <= 16'h0040;
      aux <= 1'b0;
      @(posedge core_clk);
      ee_reload <= 1'b1;
      @(posedge core_clk);
      ee_reload <= 1'b0;
      wait_n(12);
      bus(0, 8'h88, 32'h0040_0000, '1);
      wait_n(2);
      conclude();
   end
endmodule : irq_enable2_and_command_regs_tb
`default_nettype wire
